// *** hw/port9_pkg.sv ***
package port9_pkg;

    // Register word indices; the APB byte address is four times each index
    localparam logic [29:0] PU_IDX = 30'h0ffffc52;
    localparam logic [29:0] PU_HIGH_IDX = 30'h0ffffc53;
    localparam logic [29:0] OD_HIGH_IDX = 30'h0ffffc73;
    localparam logic [29:0] FS_IDX = 30'h3ffff472;
    localparam logic [29:0] FS_HIGH_IDX = 30'h3ffff473;

    // Implemented port bits and reset values
    localparam logic [15:0] PORT_MASK = 16'he3c3;
    localparam logic [15:0] OD_MASK = 16'h0003;
    localparam logic [15:0] PU_RESET = 16'h0000;
    localparam logic [15:0] OD_RESET = 16'h0000;
    localparam logic [15:0] FS_RESET = 16'h0000;

    // Open-drain register bit for each of pins 8 and 9
    localparam int OD_BIT_PIN8 = 0;
    localparam int OD_BIT_PIN9 = 1;

    // Pin positions of the alternate functions
    localparam int PIN_UART_TX = 0;
    localparam int PIN_UART_RX = 1;
    localparam int PIN_TIMER = 6;
    localparam int PIN_SER_IN = 7;
    localparam int PIN_SER_OUT = 8;
    localparam int PIN_SER_CLK = 9;
    localparam int PIN_INT_FOUR = 13;
    localparam int PIN_INT_FIVE = 14;
    localparam int PIN_INT_SIX = 15;

    // Bus answer timing
    localparam int APB_WAIT_CYCLES = 1;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_e;

endpackage : port9_pkg

// *** hw/port9_half_reg.sv ***
`timescale 1ns/10ps
module port9_half_reg #(
    parameter logic [15:0] IMPL_MASK = 16'hffff,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Byte-lane write
    input wire logic i_wr_lo,
    input wire logic i_wr_hi,
    input wire logic [7:0] i_data_lo,
    input wire logic [7:0] i_data_hi,
    // Stored value
    output logic [15:0] o_value
);

    logic [15:0] value_reg;
    logic [15:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (i_wr_lo) begin
            value_next[7:0] = i_data_lo;
        end
        if (i_wr_hi) begin
            value_next[15:8] = i_data_hi;
        end
        // Unimplemented positions never store a one
        value_next = value_next & IMPL_MASK;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            value_reg <= RESET_VAL;
        end else begin
            value_reg <= value_next;
        end
    end

    assign o_value = value_reg;

endmodule : port9_half_reg

// *** hw/port9_pin_function_control.sv ***
// Function
// - Pins 8, 9: push-pull or open-drain
// - Mode set with select zero: undefined
// - Select routes serial clock, data, timer
// - Select routes interrupts and uart pins
// - Upper byte view of select bits
// - Select register: 16, 8, 1-bit access (here 16- and 8-bit access through PSTRB only, no bit access)
// - Pull-up bit connects on-chip resistor
// - Pull-up register: word and byte views
// - Pull-up register resets to zero
// - Open-drain register resets to zero
// - Mode bit: port or alternate function
// - Output latch drives pin in output mode
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module port9_pin_function_control #(
    parameter int PORT_W = 16
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    // APB slave
    input wire logic [31:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Neighbouring port registers
    input wire logic [PORT_W-1:0] I_OUTPUT_LATCH,
    input wire logic [PORT_W-1:0] I_PORT_INPUT_MODE,
    input wire logic [PORT_W-1:0] I_MODE_CONTROL,
    // Pads
    input wire logic [PORT_W-1:0] I_PIN_IN,
    output logic [PORT_W-1:0] O_PIN_OUT,
    output logic [PORT_W-1:0] O_PIN_OE,
    output logic [PORT_W-1:0] O_PULLUP_EN,
    // Peripheral outputs toward the pins
    input wire logic I_UART_TRANSMIT_OUT,
    input wire logic I_TIMER_OUTPUT,
    input wire logic I_SERIAL_DATA_OUT,
    input wire logic I_SERIAL_CLOCK_OUT,
    input wire logic I_SERIAL_CLOCK_OE,
    // Pin inputs toward the peripherals
    output logic O_UART_RECEIVE_IN,
    output logic O_SERIAL_DATA_IN,
    output logic O_SERIAL_CLOCK_IN,
    output logic O_EXT_INTERRUPT_FOUR,
    output logic O_EXT_INTERRUPT_FIVE,
    output logic O_EXT_INTERRUPT_SIX
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Places a halfword or its upper byte in the low bits of a read word
    function automatic logic [31:0] read_view(input logic [15:0] v,
                                              input logic upper);
        logic [31:0] r;
        r = 32'h00000000;
        if (upper) begin
            r[7:0] = v[15:8];
        end else begin
            r[15:0] = v;
        end
        return r;
    endfunction : read_view

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic [29:0] word_idx;
    logic hit_pu;
    logic hit_pu_hi;
    logic hit_od;
    logic hit_fs;
    logic hit_fs_hi;
    logic hit_any;

    assign word_idx = I_PADDR[31:2];
    assign hit_pu = word_idx == port9_pkg::PU_IDX;
    assign hit_pu_hi = word_idx == port9_pkg::PU_HIGH_IDX;
    assign hit_od = word_idx == port9_pkg::OD_HIGH_IDX;
    assign hit_fs = word_idx == port9_pkg::FS_IDX;
    assign hit_fs_hi = word_idx == port9_pkg::FS_HIGH_IDX;
    assign hit_any = hit_pu | hit_pu_hi | hit_od | hit_fs | hit_fs_hi;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, then a registered answer

    port9_pkg::bus_state_e state_reg;
    port9_pkg::bus_state_e state_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic wr_fire;

    logic [15:0] pu_val;
    logic [15:0] od_val;
    logic [15:0] fs_val;

    // A write lands at the edge where the master samples ready high
    assign wr_fire = (state_reg == port9_pkg::BUS_ANSWER) & I_PSEL &
                     I_PENABLE & I_PWRITE & hit_any;

    always_comb begin
        state_next = state_reg;
        prdata_next = 32'h00000000;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        unique case (state_reg)
            port9_pkg::BUS_IDLE: begin
                if (I_PSEL && I_PENABLE) begin
                    state_next = port9_pkg::BUS_ANSWER;
                    pready_next = 1'b1;
                    pslverr_next = ~hit_any;
                    if (!I_PWRITE) begin
                        // Lower byte views share the word address
                        if (hit_pu) begin
                            prdata_next = read_view(pu_val, 1'b0);
                        end else if (hit_pu_hi) begin
                            prdata_next = read_view(pu_val, 1'b1);
                        end else if (hit_od) begin
                            prdata_next = read_view(od_val, 1'b0);
                        end else if (hit_fs) begin
                            prdata_next = read_view(fs_val, 1'b0);
                        end else if (hit_fs_hi) begin
                            prdata_next = read_view(fs_val, 1'b1);
                        end
                    end
                end
            end
            port9_pkg::BUS_ANSWER: begin
                state_next = port9_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_reg <= port9_pkg::BUS_IDLE;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign O_PRDATA = prdata_reg;
    assign O_PREADY = pready_reg;
    assign O_PSLVERR = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic pu_wr_lo;
    logic pu_wr_hi;
    logic fs_wr_lo;
    logic fs_wr_hi;
    logic od_wr;
    logic [7:0] pu_data_hi;
    logic [7:0] fs_data_hi;

    // Upper byte views carry bits 8 to 15 in lane 0
    assign pu_wr_lo = wr_fire & hit_pu & I_PSTRB[0];
    assign pu_wr_hi = wr_fire & ((hit_pu & I_PSTRB[1]) |
                                 (hit_pu_hi & I_PSTRB[0]));
    assign pu_data_hi = hit_pu_hi ? I_PWDATA[7:0] : I_PWDATA[15:8];
    assign fs_wr_lo = wr_fire & hit_fs & I_PSTRB[0];
    assign fs_wr_hi = wr_fire & ((hit_fs & I_PSTRB[1]) |
                                 (hit_fs_hi & I_PSTRB[0]));
    assign fs_data_hi = hit_fs_hi ? I_PWDATA[7:0] : I_PWDATA[15:8];
    assign od_wr = wr_fire & hit_od & I_PSTRB[0];

    port9_half_reg #(
        .IMPL_MASK(port9_pkg::PORT_MASK),
        .RESET_VAL(port9_pkg::PU_RESET)
    ) u_pullup_enable (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_wr_lo(pu_wr_lo),
        .i_wr_hi(pu_wr_hi),
        .i_data_lo(I_PWDATA[7:0]),
        .i_data_hi(pu_data_hi),
        .o_value(pu_val)
    );

    port9_half_reg #(
        .IMPL_MASK(port9_pkg::OD_MASK),
        .RESET_VAL(port9_pkg::OD_RESET)
    ) u_open_drain_select_high (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_wr_lo(od_wr),
        .i_wr_hi(1'b0),
        .i_data_lo(I_PWDATA[7:0]),
        .i_data_hi(8'h00),
        .o_value(od_val)
    );

    port9_half_reg #(
        .IMPL_MASK(port9_pkg::PORT_MASK),
        .RESET_VAL(port9_pkg::FS_RESET)
    ) u_alt_function_select (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_wr_lo(fs_wr_lo),
        .i_wr_hi(fs_wr_hi),
        .i_data_lo(I_PWDATA[7:0]),
        .i_data_hi(fs_data_hi),
        .o_value(fs_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin multiplexer

    logic [PORT_W-1:0] alt_sel;
    logic [PORT_W-1:0] pin_out_next;
    logic [PORT_W-1:0] pin_oe_next;
    logic [PORT_W-1:0] pin_out_reg;
    logic [PORT_W-1:0] pin_oe_reg;
    logic [PORT_W-1:0] pullup_reg;
    logic [PORT_W-1:0] pullup_next;
    logic [5:0] periph_in_next;
    logic [5:0] periph_in_reg;
    logic [PORT_W-1:0] alt_drive;
    logic [PORT_W-1:0] alt_data;
    logic [1:0] od_sel;

    assign alt_sel = I_MODE_CONTROL & fs_val[PORT_W-1:0];
    assign od_sel = od_val[1:0];

    always_comb begin
        alt_drive = '0;
        alt_data = '0;
        alt_drive[port9_pkg::PIN_UART_TX] = 1'b1;
        alt_data[port9_pkg::PIN_UART_TX] = I_UART_TRANSMIT_OUT;
        alt_drive[port9_pkg::PIN_TIMER] = 1'b1;
        alt_data[port9_pkg::PIN_TIMER] = I_TIMER_OUTPUT;
        alt_drive[port9_pkg::PIN_SER_OUT] = 1'b1;
        alt_data[port9_pkg::PIN_SER_OUT] = I_SERIAL_DATA_OUT;
        alt_drive[port9_pkg::PIN_SER_CLK] = I_SERIAL_CLOCK_OE;
        alt_data[port9_pkg::PIN_SER_CLK] = I_SERIAL_CLOCK_OUT;
    end

    always_comb begin
        pin_out_next = '0;
        pin_oe_next = '0;
        for (int n = 0; n < PORT_W; n++) begin
            if (!I_MODE_CONTROL[n]) begin
                // Port mode: the latch drives while output mode is set
                pin_out_next[n] = I_OUTPUT_LATCH[n];
                pin_oe_next[n] = ~I_PORT_INPUT_MODE[n];
            end else if (alt_sel[n]) begin
                pin_out_next[n] = alt_data[n];
                pin_oe_next[n] = alt_drive[n];
            end else begin
                // Undefined output: released rather than guessed
                pin_out_next[n] = 1'b0;
                pin_oe_next[n] = 1'b0;
            end
        end
        // Open drain only sinks; a high level is left to the pull-up
        if (od_sel[port9_pkg::OD_BIT_PIN8]) begin
            pin_oe_next[port9_pkg::PIN_SER_OUT] =
                pin_oe_next[port9_pkg::PIN_SER_OUT] &
                ~pin_out_next[port9_pkg::PIN_SER_OUT];
            pin_out_next[port9_pkg::PIN_SER_OUT] = 1'b0;
        end
        if (od_sel[port9_pkg::OD_BIT_PIN9]) begin
            pin_oe_next[port9_pkg::PIN_SER_CLK] =
                pin_oe_next[port9_pkg::PIN_SER_CLK] &
                ~pin_out_next[port9_pkg::PIN_SER_CLK];
            pin_out_next[port9_pkg::PIN_SER_CLK] = 1'b0;
        end
        pin_out_next = pin_out_next & port9_pkg::PORT_MASK;
        pin_oe_next = pin_oe_next & port9_pkg::PORT_MASK;
    end

    always_comb begin
        pullup_next = pu_val[PORT_W-1:0] & port9_pkg::PORT_MASK;
        // Unselected inputs rest at their idle level
        periph_in_next[0] = alt_sel[port9_pkg::PIN_UART_RX] ?
                            I_PIN_IN[port9_pkg::PIN_UART_RX] : 1'b1;
        periph_in_next[1] = alt_sel[port9_pkg::PIN_SER_IN] &
                            I_PIN_IN[port9_pkg::PIN_SER_IN];
        periph_in_next[2] = alt_sel[port9_pkg::PIN_SER_CLK] &
                            I_PIN_IN[port9_pkg::PIN_SER_CLK];
        periph_in_next[3] = alt_sel[port9_pkg::PIN_INT_FOUR] &
                            I_PIN_IN[port9_pkg::PIN_INT_FOUR];
        periph_in_next[4] = alt_sel[port9_pkg::PIN_INT_FIVE] &
                            I_PIN_IN[port9_pkg::PIN_INT_FIVE];
        periph_in_next[5] = alt_sel[port9_pkg::PIN_INT_SIX] &
                            I_PIN_IN[port9_pkg::PIN_INT_SIX];
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
            pullup_reg <= '0;
            periph_in_reg <= 6'h01;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            pullup_reg <= pullup_next;
            periph_in_reg <= periph_in_next;
        end
    end

    assign O_PIN_OUT = pin_out_reg;
    assign O_PIN_OE = pin_oe_reg;
    assign O_PULLUP_EN = pullup_reg;
    assign O_UART_RECEIVE_IN = periph_in_reg[0];
    assign O_SERIAL_DATA_IN = periph_in_reg[1];
    assign O_SERIAL_CLOCK_IN = periph_in_reg[2];
    assign O_EXT_INTERRUPT_FOUR = periph_in_reg[3];
    assign O_EXT_INTERRUPT_FIVE = periph_in_reg[4];
    assign O_EXT_INTERRUPT_SIX = periph_in_reg[5];

endmodule : port9_pin_function_control

// *** test/port9_asserts.sv ***
`timescale 1ns/10ps
module port9_asserts #(
    parameter int PORT_W = 16
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    // APB
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // Port and pads
    input wire logic [PORT_W-1:0] I_OUTPUT_LATCH,
    input wire logic [PORT_W-1:0] I_PORT_INPUT_MODE,
    input wire logic [PORT_W-1:0] I_MODE_CONTROL,
    input wire logic [PORT_W-1:0] O_PIN_OUT,
    input wire logic [PORT_W-1:0] O_PIN_OE,
    input wire logic [PORT_W-1:0] O_PULLUP_EN,
    // Peripheral inputs
    input wire logic O_UART_RECEIVE_IN,
    input wire logic O_SERIAL_DATA_IN,
    input wire logic O_EXT_INTERRUPT_SIX
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESET_N);
    ////////////////////////////////////////
    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_access;
        I_PSEL && I_PENABLE;
    endsequence
    ////////////////////////////////////////
    AST_ANSWER: assert property (s_setup ##1 s_access |=> O_PREADY)
        else $error("no answer after one wait state");
    AST_PULSE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held too long");
    AST_RDATA_IDLE: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
        else $error("read data outside answer");
    AST_ERR_READY: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");
    AST_PU_UNUSED: assert property (
        (O_PULLUP_EN & ~port9_pkg::PORT_MASK) == '0)
        else $error("pull-up on missing bit");
    AST_PIN_UNUSED: assert property (
        ((O_PIN_OE | O_PIN_OUT) & ~port9_pkg::PORT_MASK) == '0)
        else $error("missing pin driven");
    AST_PORT_MODE: assert property (!I_MODE_CONTROL[0] |=>
        O_PIN_OUT[0] == $past(I_OUTPUT_LATCH[0])
        && O_PIN_OE[0] == !$past(I_PORT_INPUT_MODE[0]))
        else $error("port mode pin wrong");
    AST_PIN8_LOW: assert property (!I_MODE_CONTROL[8]
        && !I_OUTPUT_LATCH[8] && !I_PORT_INPUT_MODE[8]
        |=> O_PIN_OE[8] && !O_PIN_OUT[8])
        else $error("pin eight not pulled low");
    AST_RX_IDLE: assert property (
        !I_MODE_CONTROL[1] |=> O_UART_RECEIVE_IN)
        else $error("receive input not idle high");
    AST_SI_IDLE: assert property (
        !I_MODE_CONTROL[7] |=> !O_SERIAL_DATA_IN)
        else $error("serial input not idle");
    AST_INT_IDLE: assert property (
        !I_MODE_CONTROL[15] |=> !O_EXT_INTERRUPT_SIX)
        else $error("interrupt input not idle");
endmodule : port9_asserts

bind port9_pin_function_control
    port9_asserts #(.PORT_W(PORT_W)) port9_asserts_inst (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_OUTPUT_LATCH(I_OUTPUT_LATCH),
    .I_PORT_INPUT_MODE(I_PORT_INPUT_MODE), .I_MODE_CONTROL(I_MODE_CONTROL),
    .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE), .O_PULLUP_EN(O_PULLUP_EN),
    .O_UART_RECEIVE_IN(O_UART_RECEIVE_IN),
    .O_SERIAL_DATA_IN(O_SERIAL_DATA_IN),
    .O_EXT_INTERRUPT_SIX(O_EXT_INTERRUPT_SIX)
);

// *** test/port9_pad_model.sv ***
`timescale 1ns/10ps
module port9_pad_model (
    // Clock
    input wire logic i_clk,
    // Pad side of the block
    input wire logic [15:0] i_pin_out,
    input wire logic [15:0] i_pin_oe,
    input wire logic [15:0] i_pullup_en,
    // Board drivers
    input wire logic [15:0] i_ext_en,
    input wire logic [15:0] i_ext_val,
    // Resolved pad level
    output logic [15:0] o_pin_level
);
    logic [15:0] float_reg = 16'h5a5a;
    // A floating pad wanders so a stale level never passes for a real one
    always @(posedge i_clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            if (i_pin_oe[n]) begin
                o_pin_level[n] = i_pin_out[n];
            end else if (i_ext_en[n]) begin
                o_pin_level[n] = i_ext_val[n];
            end else if (i_pullup_en[n]) begin
                o_pin_level[n] = 1'b1;
            end else begin
                o_pin_level[n] = float_reg[n];
            end
        end
    end
endmodule : port9_pad_model

// *** test/port9_pin_function_control_tb.sv ***
`timescale 1ns/10ps
module port9_pin_function_control_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [31:0] paddr = 32'h0, pwd = 32'h0, prd;
    logic [3:0] pstrb = 4'h0;
    logic [15:0] lat = 16'h0, imode = 16'hffff, mc = 16'h0;
    logic [15:0] ext = 16'h0, xen = 16'h0, pout, poe, pue, pin;
    logic [4:0] per = 5'h0;
    logic prdy, perr, rx, si, sck, i4, i5, i6;
    logic [15:0] pu = 16'h0, od = 16'h0, fs = 16'h0;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [29:0] ixs[6] = '{port9_pkg::PU_IDX, port9_pkg::PU_HIGH_IDX,
        port9_pkg::OD_HIGH_IDX, port9_pkg::FS_IDX, port9_pkg::FS_HIGH_IDX,
        30'h0ffffc54};
    int fails = 0, n_checks = 0, cyc = 0;
    int ri = 0;
    always #12.5 clk = ~clk;
    port9_pin_function_control port9_pin_function_control_inst (
        .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PADDR(paddr), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PWDATA(pwd), .I_PSTRB(pstrb),
        .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_OUTPUT_LATCH(lat), .I_PORT_INPUT_MODE(imode),
        .I_MODE_CONTROL(mc), .I_PIN_IN(pin), .O_PIN_OUT(pout),
        .O_PIN_OE(poe), .O_PULLUP_EN(pue), .I_UART_TRANSMIT_OUT(per[0]),
        .I_TIMER_OUTPUT(per[1]), .I_SERIAL_DATA_OUT(per[2]),
        .I_SERIAL_CLOCK_OUT(per[3]), .I_SERIAL_CLOCK_OE(per[4]),
        .O_UART_RECEIVE_IN(rx), .O_SERIAL_DATA_IN(si),
        .O_SERIAL_CLOCK_IN(sck), .O_EXT_INTERRUPT_FOUR(i4),
        .O_EXT_INTERRUPT_FIVE(i5), .O_EXT_INTERRUPT_SIX(i6));
    port9_pad_model port9_pad_model_inst (.i_clk(clk), .i_pin_out(pout),
        .i_pin_oe(poe), .i_pullup_en(pue), .i_ext_en(xen),
        .i_ext_val(ext), .o_pin_level(pin));
    ////////////////////////////////////////
    task automatic end_of_test;
        if (q.size() != 0) fails++;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic cmp32(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            fails++;
            $display("FAIL %0t bus got %h exp %h", $time, g, x);
        end
    endtask : cmp32
    task automatic cmp16(input logic [15:0] g, input logic [15:0] x);
        n_checks++;
        if (g !== x) begin
            fails++;
            $display("FAIL %0t pins got %h exp %h", $time, g, x);
        end
    endtask : cmp16
    function automatic logic [15:0] mg(logic [15:0] r, logic [15:0] d,
        logic [1:0] s, logic [15:0] m);
        mg = {s[1] ? d[15:8] : r[15:8], s[0] ? d[7:0] : r[7:0]} & m;
    endfunction : mg
    ////////////////////////////////////////
    // Answer checker; a hang of the bus is cut by the cycle ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            end_of_test();
        end
        if (prdy === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : 34'h3ffffffff;
            cmp32({31'h0, perr}, {31'h0, e[32]});
            if (e[33]) cmp32(prd, e[31:0]);
        end
    end
    task automatic acc(input logic w, input logic [29:0] ix,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic er;
        r = 32'h0;
        er = 1'b0;
        case (ix)
            port9_pkg::PU_IDX: begin
                r = {16'h0, pu};
                if (w) pu = mg(pu, d[15:0], s[1:0], port9_pkg::PORT_MASK);
            end
            port9_pkg::PU_HIGH_IDX: begin
                r = {24'h0, pu[15:8]};
                if (w) pu = mg(pu, {d[7:0], 8'h0}, {s[0], 1'b0},
                    port9_pkg::PORT_MASK);
            end
            port9_pkg::FS_IDX: begin
                r = {16'h0, fs};
                if (w) fs = mg(fs, d[15:0], s[1:0], port9_pkg::PORT_MASK);
            end
            port9_pkg::FS_HIGH_IDX: begin
                r = {24'h0, fs[15:8]};
                if (w) fs = mg(fs, {d[7:0], 8'h0}, {s[0], 1'b0},
                    port9_pkg::PORT_MASK);
            end
            port9_pkg::OD_HIGH_IDX: begin
                r = {24'h0, od[7:0]};
                if (w) od = mg(od, d[15:0], {1'b0, s[0]}, port9_pkg::OD_MASK);
            end
            default: er = 1'b1;
        endcase
        q.push_back({!w, er, r});
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {ix, 2'b00};
        pwd <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        // The wait ends when ready is seen high; only the cycle ceiling ends a hang
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : acc
    ////////////////////////////////////////
    task automatic pins;
        logic [15:0] eo, ee, lv;
        logic [5:0] ep;
        @(posedge clk);
        lat <= 16'($urandom);
        imode <= 16'($urandom);
        per <= 5'($urandom);
        ext <= 16'($urandom);
        // Pads neither driven nor pulled would float
        xen <= 16'($urandom) | ~pu;
        mc <= 16'($urandom);
        repeat (3) @(posedge clk);
        for (int n = 0; n < 16; n++) begin
            eo[n] = mc[n] ? 1'b0 : lat[n];
            ee[n] = mc[n] ? 1'b0 : !imode[n];
            if (mc[n] && fs[n]) begin
                case (n)
                    0: {ee[n], eo[n]} = {1'b1, per[0]};
                    6: {ee[n], eo[n]} = {1'b1, per[1]};
                    8: {ee[n], eo[n]} = {1'b1, per[2]};
                    9: {ee[n], eo[n]} = {per[4], per[3]};
                    default: ;
                endcase
            end
            if (n >= 8 && n <= 9 && od[n-8]) begin
                ee[n] = ee[n] & !eo[n];
                eo[n] = 1'b0;
            end
        end
        eo &= port9_pkg::PORT_MASK;
        ee &= port9_pkg::PORT_MASK;
        lv = (ee & eo) | (~ee & xen & ext) | (~ee & ~xen);
        ep[0] = (mc[1] && fs[1]) ? lv[1] : 1'b1;
        ep[1] = mc[7] & fs[7] & lv[7];
        ep[2] = mc[9] & fs[9] & lv[9];
        ep[3] = mc[13] & fs[13] & lv[13];
        ep[4] = mc[14] & fs[14] & lv[14];
        ep[5] = mc[15] & fs[15] & lv[15];
        cmp16(pout, eo);
        cmp16(poe, ee);
        cmp16(pue, pu);
        cmp16({10'h0, i6, i5, i4, sck, si, rx}, {10'h0, ep});
    endtask : pins
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h3a6a));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ixs[k]) acc(1'b0, ixs[k], 32'h0, 4'h0);
        for (int k = 0; k < 40; k++) begin
            ri = $urandom_range(5);
            acc(1'b1, ixs[ri], $urandom, 4'($urandom));
            acc(1'b0, ixs[ri], 32'h0, 4'h0);
        end
        for (int k = 0; k < 30; k++) begin
            // Back to port mode so selects never change under a live pin
            @(posedge clk);
            mc <= 16'h0;
            acc(1'b1, port9_pkg::FS_IDX, $urandom, 4'h3);
            acc(1'b1, port9_pkg::OD_HIGH_IDX, $urandom, 4'h1);
            acc(1'b1, port9_pkg::PU_IDX, $urandom, 4'h3);
            pins();
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        pu = 16'h0;
        od = 16'h0;
        fs = 16'h0;
        foreach (ixs[k]) acc(1'b0, ixs[k], 32'h0, 4'h0);
        pins();
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule : port9_pin_function_control_tb
